// file: logic/tmr_consts.vh
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// Register byte offsets on the Wishbone bus
`define TMR_OFS_COUNT      8'h00
`define TMR_OFS_OPTION     8'h04
`define TMR_OFS_INTCTL     8'h08

// Option register field positions
`define TMR_OPT_SRC_BIT    5
`define TMR_OPT_EDGE_BIT   4
`define TMR_OPT_ASSIGN_BIT 3
`define TMR_OPT_PS_MSB     2
`define TMR_OPT_PS_LSB     0

// Interrupt control field positions
`define TMR_INT_EN_BIT     5
`define TMR_INT_FLAG_BIT   2

// Reset values and the count limit
`define TMR_OPTION_RST     6'h3F
`define TMR_COUNT_RST      8'h00
`define TMR_COUNT_MAX      8'hFF

// Timing counts in instruction cycles
`define TMR_WRITE_INHIBIT  2'h2

// Quadrature phases of the four-clock instruction cycle
`define TMR_PHASE_Q2       2'h1
`define TMR_PHASE_Q4       2'h3

`endif

// file: logic/tmr_prescaler.v
`include "tmr_consts.vh"
`default_nettype none

module tmr_prescaler #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       reset_n,
	// Count control
	input  wire       tick,
	input  wire       clear,
	input  wire [2:0] ratio_sel,
	// Divided output
	output reg        div_out
);

	reg  [WIDTH-1:0] stage;
	wire [WIDTH:0]   carry;

	assign carry[0] = tick;

	////////////////////////////////////////////////////////////////////////
	// ripple toggle stages
	// Each stage toggles on the carry of the ones below, so every bit is a
	// symmetrical square wave at half the rate of its neighbour.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_stage
			assign carry[i+1] = carry[i] & stage[i];
			always @(posedge sys_clk or negedge reset_n)
			begin
				if (!reset_n)
					stage[i] <= 1'b0;
				else if (clear)
					stage[i] <= 1'b0;
				else if (carry[i])
					stage[i] <= ~stage[i];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// code picks the stage
	// Stage k divides by 2 to the power k+1, so code 000 is 1:2.
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			div_out <= 1'b0;
		else if (clear)
			div_out <= 1'b0;
		else
			div_out <= stage[ratio_sel];
	end

endmodule // tmr_prescaler

`default_nettype wire

// file: logic/tmr_timer0.v
// Our own choices: the address map and the Wishbone slave port.
`include "tmr_consts.vh"
`default_nettype none


module tmr_timer0 #(
	parameter PS_WIDTH = 8
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        reset_n,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Pin and core events
	input  wire        ext_count_input,
	input  wire        sleep_mode,
	input  wire        watchdog_clear_op,
	input  wire        wdt_tick,
	// Results
	output reg         overflow_irq,
	output reg         wdt_postscaled
);

	////////////////////////////////////////////////////////////////////////
	// Address decode, shared by read and write paths
	function hit;
		input [7:0] adr;
		input [7:0] ofs;
		begin
			hit = (adr[7:2] == ofs[7:2]);
		end
	endfunction

	// Option reset value (six bits), so single fields can be picked without truncation
	localparam [5:0] OPT_RST = `TMR_OPTION_RST;

	reg  [7:0] count_register;
	reg        clock_source_select;
	reg        source_edge_select;
	reg        prescaler_assign;
	reg  [2:0] prescale_select;
	reg        overflow_flag;
	reg        overflow_irq_enable;

	reg  [1:0] q_phase;
	reg  [1:0] inhibit;
	reg        ext_meta;
	reg        ext_sync;
	reg        ext_pol_d;
	reg        samp_last;

	wire       bus_req;
	wire       bus_wr;
	wire       count_write;
	wire       option_write;
	wire       intctl_write;
	wire       q2;
	wire       q4;
	wire       ext_pol;
	wire       ext_edge;
	wire       ps_tick;
	wire       ps_clear;
	wire       ps_out;
	wire       cnt_level;
	wire       sample_now;
	wire       samp_rise;
	wire       use_sampled;
	wire       inc_req;
	wire       wrap;
	reg  [31:0] next_rdata;

	////////////////////////////////////////////////////////////////////////
	// Wishbone classic slave
	// Ack comes one cycle after the request; writes land on the ack edge
	// so the master sees them take effect exactly when it samples ack.
	assign bus_req      = wb_cyc_i & wb_stb_i;
	assign bus_wr       = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign count_write  = bus_wr & hit(wb_adr_i, `TMR_OFS_COUNT);
	assign option_write = bus_wr & hit(wb_adr_i, `TMR_OFS_OPTION);
	assign intctl_write = bus_wr & hit(wb_adr_i, `TMR_OFS_INTCTL);

	always @*
	begin
		next_rdata = 32'h0000_0000;
		if (hit(wb_adr_i, `TMR_OFS_COUNT))
			next_rdata[7:0] = count_register;
		else if (hit(wb_adr_i, `TMR_OFS_OPTION))
		begin
			next_rdata[`TMR_OPT_SRC_BIT]    = clock_source_select;
			next_rdata[`TMR_OPT_EDGE_BIT]   = source_edge_select;
			next_rdata[`TMR_OPT_ASSIGN_BIT] = prescaler_assign;
			next_rdata[`TMR_OPT_PS_MSB:`TMR_OPT_PS_LSB] = prescale_select;
		end
		else if (hit(wb_adr_i, `TMR_OFS_INTCTL))
		begin
			next_rdata[`TMR_INT_EN_BIT]   = overflow_irq_enable;
			next_rdata[`TMR_INT_FLAG_BIT] = overflow_flag;
		end
	end

	// no prescaler register
	// The divider state is never mapped, so it can be neither read nor set.
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req & ~wb_ack_o)
				wb_dat_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Option register
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clock_source_select <= OPT_RST[`TMR_OPT_SRC_BIT];
			source_edge_select  <= OPT_RST[`TMR_OPT_EDGE_BIT];
			prescaler_assign    <= OPT_RST[`TMR_OPT_ASSIGN_BIT];
			prescale_select     <= OPT_RST[`TMR_OPT_PS_MSB:`TMR_OPT_PS_LSB];
		end
		else if (option_write)
		begin
			clock_source_select <= wb_dat_i[`TMR_OPT_SRC_BIT];
			source_edge_select  <= wb_dat_i[`TMR_OPT_EDGE_BIT];
			prescaler_assign    <= wb_dat_i[`TMR_OPT_ASSIGN_BIT];
			prescale_select     <= wb_dat_i[`TMR_OPT_PS_MSB:`TMR_OPT_PS_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Quadrature phases: four system clocks make one instruction cycle
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			q_phase <= 2'h0;
		else
			q_phase <= q_phase + 2'h1;
	end

	assign q2 = (q_phase == `TMR_PHASE_Q2);
	assign q4 = (q_phase == `TMR_PHASE_Q4);

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	// The pin is metastable-hardened before anything looks at it, which caps
	// the external rate at half the system clock even with a prescaler.
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_meta  <= 1'b0;
			ext_sync  <= 1'b0;
			// Idle pin seen through the reset edge select, else a false edge follows reset
			ext_pol_d <= OPT_RST[`TMR_OPT_EDGE_BIT];
		end
		else
		begin
			ext_meta  <= ext_count_input;
			ext_sync  <= ext_meta;
			ext_pol_d <= ext_pol;
		end
	end

	assign ext_pol  = ext_sync ^ source_edge_select;
	assign ext_edge = ext_pol & ~ext_pol_d;

	////////////////////////////////////////////////////////////////////////
	// Shared prescaler
	// owner picks source
	// halted in sleep
	// The watchdog keeps its share in sleep, since it must run there.
	assign ps_tick = prescaler_assign ? wdt_tick :
		(sleep_mode ? 1'b0 : (clock_source_select ? ext_edge : q4));

	assign ps_clear = prescaler_assign ? watchdog_clear_op : count_write;

	tmr_prescaler #(
		.WIDTH     (PS_WIDTH)
	) u_prescaler (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.tick      (ps_tick),
		.clear     (ps_clear),
		.ratio_sel (prescale_select),
		.div_out   (ps_out)
	);

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			wdt_postscaled <= 1'b0;
		else
			wdt_postscaled <= prescaler_assign & ps_out;
	end

	////////////////////////////////////////////////////////////////////////
	// Post-prescaler synchronisation
	// bypass when assigned to the watchdog
	assign cnt_level = prescaler_assign ? ext_pol : ps_out;

	assign sample_now = q2 | q4;

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			samp_last <= OPT_RST[`TMR_OPT_EDGE_BIT];
		else if (sample_now)
			samp_last <= cnt_level;
	end

	assign samp_rise = sample_now & cnt_level & ~samp_last;

	////////////////////////////////////////////////////////////////////////
	// Write inhibit
	// two cycle hold-off
	// Counted on Q4 so the cycle holding a write made before Q4 is the first of the two.
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			inhibit <= 2'h0;
		else if (count_write)
			inhibit <= `TMR_WRITE_INHIBIT;
		else if (q4 && inhibit != 2'h0)
			inhibit <= inhibit - 2'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Count register
	// timer steps unprescaled only while the watchdog owns the divider
	assign use_sampled = clock_source_select | ~prescaler_assign;
	assign inc_req = ~sleep_mode & (inhibit == 2'h0) &
		(use_sampled ? samp_rise : q4);

	assign wrap = inc_req & (count_register == `TMR_COUNT_MAX);

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_register <= `TMR_COUNT_RST;
		else if (count_write)
			count_register <= wb_dat_i[7:0];
		else if (inc_req)
			count_register <= count_register + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt control
	// sticky flag
	// clear write wins
	// A same-cycle wrap is dropped when software writes the flag; that race
	// is accepted so a clear is never undone behind the handler's back.
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			overflow_flag       <= 1'b0;
			overflow_irq_enable <= 1'b0;
		end
		else if (intctl_write)
		begin
			overflow_flag       <= wb_dat_i[`TMR_INT_FLAG_BIT];
			overflow_irq_enable <= wb_dat_i[`TMR_INT_EN_BIT];
		end
		else if (wrap)
			overflow_flag <= 1'b1;
	end

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			overflow_irq <= 1'b0;
		else
			overflow_irq <= overflow_flag & overflow_irq_enable;
	end

endmodule // tmr_timer0

`default_nettype wire

// file: testbench/tmr_timer0_assertions.sv
`default_nettype none
module tmr_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Results
	input wire logic        overflow_irq,
	input wire logic        wdt_postscaled
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] opt;
	wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
	wire rd = wb_ack_o && !wb_we_i;
	// Shadow of the option byte, the owner bit is not visible at the ports
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
			opt <= 8'h3F;
		else if (wr && wb_adr_i[7:2] == 6'h01)
			opt <= wb_dat_i[7:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_int_wr;
		wr && wb_adr_i[7:2] == 6'h02;
	endsequence
	a_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_upper_zero: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_unmapped_zero: assert property (rd && wb_adr_i[7:2] > 6'h02 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_intctl_bits: assert property (
		rd && wb_adr_i[7:2] == 6'h02 |-> (wb_dat_o[7:0] & 8'hDB) == 8'h00)
		else $error("stray control bits");
	a_irq_masked: assert property (
		s_int_wr ##0 !wb_dat_i[5] |-> ##2 !overflow_irq)
		else $error("masked request raised");
	a_irq_raised: assert property (
		s_int_wr ##0 (wb_dat_i[5] && wb_dat_i[2]) |-> ##2 overflow_irq [*2])
		else $error("request not raised");
	a_wdt_off: assert property (
		!opt[3] && !$past(opt[3]) |-> !wdt_postscaled)
		else $error("watchdog output while counter owns");
endmodule // tmr_checker
bind tmr_timer0 tmr_checker chk_u (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .overflow_irq, .wdt_postscaled);
`default_nettype wire

// file: testbench/tmr_pin_src.sv
`default_nettype none
module tmr_pin_src (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// Burst of toggles
	input wire logic       go,
	input wire logic [9:0] num,
	input wire logic [3:0] half,
	// Count pin
	output logic           pin,
	output logic           busy
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] left;
	logic [3:0] cnt;
	// Pin stands still between bursts; each level lasts half clocks
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
		begin
			pin <= 1'b0;
			busy <= 1'b0;
			left <= 10'h0;
			cnt <= 4'h0;
		end
		else if (go && !busy)
		begin
			left <= num;
			cnt <= half;
			busy <= (num != 10'h0);
		end
		else if (busy && cnt > 4'h1)
			cnt <= cnt - 4'h1;
		else if (busy)
		begin
			pin <= ~pin;
			cnt <= half;
			left <= left - 10'h1;
			busy <= (left != 10'h1);
		end
endmodule // tmr_pin_src
`default_nettype wire

// file: testbench/timer0_with_shared_prescaler_tb.sv
`default_nettype none
module timer0_with_shared_prescaler_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, reset_n = 0, cyc = 0, we = 0, go = 0, slp = 0, wclr = 0, wtick = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat;
	logic ack, irq, wdtp, pin, busy;
	logic wt_on = 1, wt_man = 0, wc_man = 0;
	logic [9:0] num = 10'h0;
	logic [3:0] half = 4'h4;
	logic [7:0] expq[$];
	int errors = 0, num_checks = 0, n;
	always #12.5 sys_clk = ~sys_clk;
	tmr_timer0 dut_u (.sys_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ext_count_input(pin), .sleep_mode(slp), .watchdog_clear_op(wclr | wc_man),
		.wdt_tick(wtick | wt_man), .overflow_irq(irq), .wdt_postscaled(wdtp));
	tmr_pin_src src_u (.sys_clk, .reset_n, .go, .num, .half, .pin, .busy);
	////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
			errors++;
		end
	endtask
	task end_sim;
		$display("errors %0d num_checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		t = 0;
		do @(posedge sys_clk); while (ack !== 1'b1 && ++t < 20);
		if (t >= 20)
		begin
			errors++;
			end_sim;
		end
		cyc <= 0;
		@(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(0, a, 32'h0);
	endtask
	task toggles(input int k);
		int t;
		// Let the two-cycle write hold-off run out before the first edge
		repeat (8) @(posedge sys_clk);
		num <= k[9:0];
		half <= 4'h3 + 4'($urandom % 4);
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
		t = 0;
		do @(posedge sys_clk); while (busy !== 1'b0 && ++t < 20000);
		if (t >= 20000)
		begin
			errors++;
			end_sim;
		end
		repeat (8) @(posedge sys_clk);
	endtask
	// Read data checked against the oldest note
	always @(posedge sys_clk)
		if (ack === 1'b1 && we === 1'b0)
			chk(rdat, {24'h0, expq.pop_front()});
	always @(posedge sys_clk)
	begin
		wtick <= wt_on & 1'($urandom % 2);
		wclr <= wt_on & (($urandom % 16) == 0);
	end
	////////////////////////////////////////
	initial
	begin
		void'($urandom(78919));
		repeat (5) @(posedge sys_clk);
		reset_n <= 1;
		rd(8'h04, 8'h3F);
		rd(8'h00, 8'h00);
		rd(8'h08, 8'h00);
		bus(1, 8'h0C, 32'hFF);
		rd(8'h0C, 8'h00);
		bus(1, 8'h04, 32'h08);
		bus(1, 8'h00, 32'hF0);
		repeat (39) @(posedge sys_clk);
		rd(8'h00, 8'hF8);
		bus(1, 8'h08, 32'h00);
		bus(1, 8'h00, 32'hFE);
		repeat (39) @(posedge sys_clk);
		rd(8'h00, 8'h06);
		rd(8'h08, 8'h04);
		chk({31'h0, irq}, 32'h0);
		bus(1, 8'h08, 32'h24);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		rd(8'h08, 8'h24);
		bus(1, 8'h08, 32'h20);
		rd(8'h08, 8'h20);
		chk({31'h0, irq}, 32'h0);
		slp <= 1;
		bus(1, 8'h00, 32'h55);
		repeat (40) @(posedge sys_clk);
		rd(8'h00, 8'h55);
		slp <= 0;
		// Odd toggles leave one edge kind short, so polarity shows
		for (int e = 0; e < 2; e++)
		begin
			n = 1 + $urandom % 8;
			bus(1, 8'h04, 32'h28 | (e << 4));
			bus(1, 8'h00, 32'h0);
			toggles(2 * n - 1);
			rd(8'h00, 8'(n));
		end
		for (int c = 0; c < 8; c++)
		begin
			bus(1, 8'h04, 32'h20 | c);
			bus(1, 8'h00, 32'h0);
			toggles(4 << c);
			rd(8'h00, 8'h01);
		end
		// Watchdog owns the divider at 1:2: one tick shows, a clear removes it
		wt_on <= 0;
		bus(1, 8'h04, 32'h08);
		wc_man <= 1;
		@(posedge sys_clk);
		wc_man <= 0;
		wt_man <= 1;
		@(posedge sys_clk);
		wt_man <= 0;
		repeat (3) @(posedge sys_clk);
		chk({31'h0, wdtp}, 32'h1);
		wc_man <= 1;
		@(posedge sys_clk);
		wc_man <= 0;
		repeat (3) @(posedge sys_clk);
		chk({31'h0, wdtp}, 32'h0);
		end_sim;
	end
endmodule // timer0_with_shared_prescaler_tb
`default_nettype wire
